// [logic/mux_cfg_logic.sv]
// Our own choices: strobed register access and the register offsets.
module mux_cfg_logic
    import mux_cfg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Board straps
    input wire logic i_expansion,
    input wire logic [3:0] i_switch,
    input wire logic i_mux_enabled,
    // Character slot
    input wire logic i_chr_valid,
    input wire logic [7:0] i_chr,
    input wire logic [2:0] i_chr_port,
    input wire logic i_direction_select_signal,
    input wire logic i_port_config_word_len8,
    output logic o_chr_valid,
    output logic [7:0] o_chr,
    output logic o_chr_special,
    output logic o_chr_irq,
    // Control block address request
    input wire logic i_cb_req,
    input wire logic [2:0] i_cb_port,
    output logic o_cb_valid,
    output logic [15:0] o_cb_addr,
    // Device select decode
    input wire logic [5:0] i_dev_sel,
    output logic o_sel_mux,
    output logic o_sel_console_input_channel,
    output logic o_sel_console_output_channel
);

    // Software state
    logic [11:0] config_word; // Block size, option, top source, msb mode, codes, set
    logic [7:0] area_base; // Upper eight bits of the control area
    logic [7:0] special_req; // Per-port special interrupt request
    logic [7:0] last_chr; // Last character processed
    logic last_special; // Special flag of that character

    // Config fields
    wire blk_size_type blk_size = blk_size_type'(config_word[CFG_SIZE_LSB+:2]);
    wire logic [1:0] flag_opt = config_word[CFG_OPT_LSB+:2];
    wire top_src_type top_src = top_src_type'(config_word[CFG_TOP_LSB+:2]);
    wire logic msb_alt = config_word[CFG_MSB_ALT];
    wire logic dev_alt = config_word[CFG_DEV_ALT];
    wire logic [3:0] main_set = config_word[CFG_SET_LSB+:4];

    // Register decode
    wire logic hit_config = (i_addr == REG_CONFIG);
    wire logic hit_base = (i_addr == REG_AREA_BASE);
    wire logic hit_req = (i_addr == REG_SPECIAL_REQ);
    wire logic hit_status = (i_addr == REG_STATUS);
    wire logic wr_config = i_wr && hit_config;
    // Base stays put once multiplexing runs
    wire logic wr_base = i_wr && hit_base && !i_mux_enabled;
    wire logic wr_req = i_wr && hit_req;

    // Set number for this board section, msb in bit 3
    // Switch 1 sits on bit 3; a closed switch reads as zero
    wire logic [3:0] set_num = i_expansion ? i_switch : main_set;

    // Lookup address: top bit from the chosen source
    logic top_bit;
    always_comb begin
        case (top_src)
            TOP_DIR: top_bit = i_direction_select_signal;
            TOP_LOW: top_bit = 1'b0;
            TOP_HIGH: top_bit = 1'b1;
            TOP_CHAR: top_bit = i_chr[7];
            default: top_bit = 1'b0;
        endcase
    end
    wire logic [7:0] lut_addr = {top_bit, i_chr[6:0]};

    // Special character table, 256 entries of four flags
    logic [3:0] lut [0:255];
    for (genvar a = 0; a < 256; a++) begin : g_lut
        localparam int C = a % 128;
        localparam bit HI = (a >= 128);
        // Flag 0: codes below 40 or above 173 in seven bits
        assign lut[a][0] = (C < 8'o40) || (C > 8'o173);
        // Flag 1: 3, 4, 31 on both halves
        assign lut[a][1] = (C == 8'o3) || (C == 8'o4) || (C == 8'o31);
        // Flag 2: 0, 4, 15, 21, 23 low half; 136 high half
        assign lut[a][2] = HI ? (C == 8'o136) :
            ((C == 8'o0) || (C == 8'o4) || (C == 8'o15) ||
             (C == 8'o21) || (C == 8'o23));
        // Flag 3: output set low half, input set adds 10, 32, 33
        assign lut[a][3] = (C == 8'o0) || (C >= 8'o3 && C <= 8'o6) ||
            (C == 8'o14) || (C == 8'o15) || (C == 8'o25) ||
            (C == 8'o27) || (C == 8'o30) || (C == 8'o31) ||
            (HI && ((C == 8'o10) || (C == 8'o32) || (C == 8'o33)));
    end
    wire logic [3:0] lut_word = lut[lut_addr];
    wire logic is_special = lut_word[flag_opt];

    // Top-bit adjustment on incoming characters of requesting ports
    wire logic port_req = special_req[i_chr_port];
    logic fixed_msb;
    always_comb begin
        if (!i_direction_select_signal || !port_req) begin
            fixed_msb = i_chr[7]; // Output or other ports untouched
        end else if (!msb_alt) begin
            fixed_msb = 1'b1;
        end else begin
            fixed_msb = i_port_config_word_len8 & i_chr[7];
        end
    end

    // Control block offset: set and port scaled by block size
    wire logic [6:0] slot = {set_num, i_cb_port};
    logic [15:0] cb_offset;
    always_comb begin
        case (blk_size)
            BLK_40: cb_offset = {4'h0, slot, 5'h00};
            BLK_20: cb_offset = {5'h00, slot, 4'h0};
            BLK_10: cb_offset = {6'h00, slot, 3'h0};
            default: cb_offset = {4'h0, slot, 5'h00};
        endcase
    end
    wire logic [15:0] next_cb_addr = {area_base, 8'h00} + cb_offset;

    // Device select codes
    wire logic [5:0] mux_code = dev_alt ? MUX_CODE_ALT : MUX_CODE_STD;
    wire logic [5:0] con_in_code = dev_alt ? CON_IN_CODE_ALT : CON_IN_CODE_STD;
    wire logic [5:0] con_out_code = dev_alt ? CON_OUT_CODE_ALT : CON_OUT_CODE_STD;
    assign o_sel_mux = (i_dev_sel == mux_code);
    assign o_sel_console_input_channel = (i_dev_sel == con_in_code);
    assign o_sel_console_output_channel = (i_dev_sel == con_out_code);

    // Read data mux
    wire logic [15:0] status_word = {3'h0, last_special, set_num, last_chr};
    wire logic [15:0] next_rdata =
        hit_config ? {4'h0, config_word} :
        hit_base ? {8'h00, area_base} :
        hit_req ? {8'h00, special_req} :
        hit_status ? status_word : 16'h0000;

    // Software registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            config_word <= CONFIG_RESET;
            area_base <= AREA_BASE_RESET;
            special_req <= SPECIAL_REQ_RESET;
        end else begin
            if (wr_config) begin
                config_word <= i_wdata[11:0];
            end
            if (wr_base) begin
                area_base <= i_wdata[7:0];
            end
            if (wr_req) begin
                special_req <= i_wdata[7:0];
            end
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? next_rdata : 16'h0000;
        end
    end

    // Character result, one cycle after the slot input
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_chr_valid <= 1'b0;
            o_chr <= 8'h00;
            o_chr_special <= 1'b0;
            o_chr_irq <= 1'b0;
        end else begin
            o_chr_valid <= i_chr_valid;
            o_chr <= i_chr_valid ? {fixed_msb, i_chr[6:0]} : o_chr;
            o_chr_special <= i_chr_valid && is_special;
            o_chr_irq <= i_chr_valid && is_special && port_req;
        end
    end

    // Last character seen, for status reads
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            last_chr <= 8'h00;
            last_special <= 1'b0;
        end else if (i_chr_valid) begin
            last_chr <= {fixed_msb, i_chr[6:0]};
            last_special <= is_special;
        end
    end

    // Control block address, one cycle after request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cb_valid <= 1'b0;
            o_cb_addr <= 16'h0000;
        end else begin
            o_cb_valid <= i_cb_req;
            o_cb_addr <= i_cb_req ? next_cb_addr : o_cb_addr;
        end
    end

    // Checks
    sequence s_chr_in;
        i_chr_valid && i_direction_select_signal && special_req[i_chr_port];
    endsequence
    sequence s_chr_out;
        ##1 o_chr_valid;
    endsequence

    a_irq_needs_req: assert property (@(posedge i_clk) disable iff (i_rst)
        o_chr_irq |-> $past(special_req[i_chr_port]) && o_chr_special)
        else $error("interrupt on non-requesting port");
    a_msb_forced: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_chr_in and !msb_alt) |-> s_chr_out ##0 o_chr[7])
        else $error("incoming msb not forced");
    a_msb_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_chr_in and msb_alt && !i_port_config_word_len8) |-> ##1 !o_chr[7])
        else $error("7-bit msb not cleared");
    a_slot_latency: assert property (@(posedge i_clk) disable iff (i_rst)
        i_chr_valid |=> o_chr_valid ##0 (o_chr[6:0] == $past(i_chr[6:0])))
        else $error("character not out in next cycle");
    a_default_set: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h0) |=>
        (o_chr_special == (($past(i_chr[6:0]) < 7'o40) || ($past(i_chr[6:0]) > 7'o173))))
        else $error("default special set wrong");
    a_opt3_out: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h3 && top_src == TOP_DIR &&
         !i_direction_select_signal && i_chr[6:0] == 7'o10) |=> !o_chr_special)
        else $error("output set flags code 10");
    a_base_locked: assert property (@(posedge i_clk) disable iff (i_rst)
        i_mux_enabled |=> $stable(area_base))
        else $error("base changed while enabled");
    a_cb_addr: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cb_req && blk_size == BLK_40) |=>
        (o_cb_addr == {$past(area_base), 8'h00} + {4'h0, $past(slot), 5'h00}))
        else $error("control block address wrong");
    a_std_code: assert property (@(posedge i_clk) disable iff (i_rst)
        (!dev_alt && i_dev_sel == 6'o25) |-> o_sel_mux)
        else $error("standard code not decoded");
    a_alt_codes: assert property (@(posedge i_clk) disable iff (i_rst)
        dev_alt |-> (o_sel_console_output_channel == (i_dev_sel == 6'o51)))
        else $error("alternative console code wrong");

    // Control block request, then its answer one cycle on
    sequence s_cb_req;
        i_cb_req;
    endsequence
    sequence s_cb_answer;
        ##1 o_cb_valid;
    endsequence

    // Every request is answered in the next cycle
    a_cb_answer: assert property (@(posedge i_clk) disable iff (i_rst)
        s_cb_req |-> s_cb_answer)
        else $error("control block request not answered");
    // Main board set comes from the config word
    a_cb_main: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_cb_req and !i_expansion && blk_size == BLK_40) |-> s_cb_answer ##0
        (o_cb_addr == {$past(area_base), 8'h00} +
        {4'h0, $past(main_set), $past(i_cb_port), 5'h00}))
        else $error("main board set misplaced");
    // Expansion set comes straight from the switches
    a_cb_switch: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_cb_req and i_expansion && blk_size == BLK_10) |-> s_cb_answer ##0
        (o_cb_addr == {$past(area_base), 8'h00} +
        {6'h00, $past(i_switch), $past(i_cb_port), 3'h0}))
        else $error("expansion set misplaced");
    // Twenty-word blocks sit sixteen words apart
    a_cb_size20: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_cb_req and blk_size == BLK_20) |-> s_cb_answer ##0
        (o_cb_addr == {$past(area_base), 8'h00} +
        {5'h00, $past(set_num), $past(i_cb_port), 4'h0}))
        else $error("twenty-word block address wrong");
    // Ten-word blocks sit eight words apart
    a_cb_size10: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_cb_req and blk_size == BLK_10) |-> s_cb_answer ##0
        (o_cb_addr == {$past(area_base), 8'h00} +
        {6'h00, $past(set_num), $past(i_cb_port), 3'h0}))
        else $error("ten-word block address wrong");
    // Option 1 flags three codes whatever the top bit
    a_opt1_set: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h1) |=>
        (o_chr_special == ($past(i_chr[6:0]) inside {7'o3, 7'o4, 7'o31})))
        else $error("option 1 special set wrong");
    // Option 2 uses the low half of the table
    a_opt2_set: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h2 && top_src == TOP_LOW) |=>
        (o_chr_special == ($past(i_chr[6:0]) inside {7'o0, 7'o4, 7'o15, 7'o21, 7'o23})))
        else $error("option 2 special set wrong");
    // Option 2a uses the high half of the table
    a_opt2a_set: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h2 && top_src == TOP_HIGH) |=>
        (o_chr_special == ($past(i_chr[6:0]) == 7'o136)))
        else $error("option 2a special set wrong");
    // Top bit from the character picks the table half
    a_top_char: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h2 && top_src == TOP_CHAR) |=>
        (o_chr_special == ($past(i_chr[7]) ? ($past(i_chr[6:0]) == 7'o136) :
        ($past(i_chr[6:0]) inside {7'o0, 7'o4, 7'o15, 7'o21, 7'o23}))))
        else $error("character msb not used as top bit");
    // Option 3 input set adds three codes
    a_opt3_in: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && flag_opt == 2'h3 && top_src == TOP_DIR &&
         i_direction_select_signal) |=>
        (o_chr_special == ($past(i_chr[6:0]) inside {7'o0, 7'o3, 7'o4, 7'o5, 7'o6,
        7'o10, 7'o14, 7'o15, 7'o25, 7'o27, 7'o30, 7'o31, 7'o32, 7'o33})))
        else $error("option 3 input set wrong");
    // Ports without a request keep their incoming msb
    a_msb_other: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && !special_req[i_chr_port]) |=> (o_chr[7] == $past(i_chr[7])))
        else $error("msb changed on non-requesting port");
    // 8-bit ports keep their msb in the alternative mode
    a_msb_kept: assert property (@(posedge i_clk) disable iff (i_rst)
        (s_chr_in and msb_alt && i_port_config_word_len8) |-> s_chr_out ##0
        (o_chr[7] == $past(i_chr[7])))
        else $error("8-bit msb not kept");
    // Requesting ports raise the interrupt with the flag
    a_irq_on_req: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_chr_valid && special_req[i_chr_port]) |=> (o_chr_irq == o_chr_special))
        else $error("interrupt missing on requesting port");
    // Exact code decode in both modes
    a_std_exact: assert property (@(posedge i_clk) disable iff (i_rst)
        !dev_alt |-> (o_sel_mux == (i_dev_sel == 6'o25)))
        else $error("standard code decode wrong");
    a_alt_mux: assert property (@(posedge i_clk) disable iff (i_rst)
        dev_alt |-> (o_sel_mux == (i_dev_sel == 6'o45)))
        else $error("alternative multiplexer code wrong");
    a_alt_input: assert property (@(posedge i_clk) disable iff (i_rst)
        dev_alt |-> (o_sel_console_input_channel == (i_dev_sel == 6'o50)))
        else $error("alternative input code wrong");
    // Base returns to its default after any reset
    a_base_default: assert property (@(posedge i_clk)
        $fell(i_rst) |-> (area_base == AREA_BASE_RESET))
        else $error("base not at default after reset");
endmodule

// [logic/mux_cfg_pkg.sv]
package mux_cfg_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_AREA_BASE = 8'h04;
    localparam logic [7:0] REG_SPECIAL_REQ = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    // Config register field positions
    localparam int CFG_SIZE_LSB = 0;
    localparam int CFG_OPT_LSB = 2;
    localparam int CFG_TOP_LSB = 4;
    localparam int CFG_MSB_ALT = 6;
    localparam int CFG_DEV_ALT = 7;
    localparam int CFG_SET_LSB = 8;
    // Values after reset
    localparam logic [7:0] AREA_BASE_RESET = 8'h3c;
    localparam logic [11:0] CONFIG_RESET = 12'h000;
    localparam logic [7:0] SPECIAL_REQ_RESET = 8'h00;
    // Geometry
    localparam int PORTS_PER_SET = 8;
    localparam int SET_COUNT = 16;
    // Device select codes
    localparam logic [5:0] MUX_CODE_STD = 6'h15;
    localparam logic [5:0] MUX_CODE_ALT = 6'h25;
    localparam logic [5:0] CON_IN_CODE_STD = 6'h08;
    localparam logic [5:0] CON_OUT_CODE_STD = 6'h09;
    localparam logic [5:0] CON_IN_CODE_ALT = 6'h28;
    localparam logic [5:0] CON_OUT_CODE_ALT = 6'h29;
    // Control block size selection
    typedef enum logic [1:0] {
        BLK_40 = 2'h0,
        BLK_20 = 2'h1,
        BLK_10 = 2'h2
    } blk_size_type;
    // Source of the top lookup address bit
    typedef enum logic [1:0] {
        TOP_DIR = 2'h0,
        TOP_LOW = 2'h1,
        TOP_HIGH = 2'h2,
        TOP_CHAR = 2'h3
    } top_src_type;
endpackage

// [testbench/host_bus_model.sv]
module host_bus_model
    import mux_cfg_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Read data coming back from the block
    input wire logic [15:0] i_rdata,
    // Register strobes, address, data and run mode
    output logic [7:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic o_mux_enabled
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        {o_addr, o_wdata, o_wr, o_rd, o_mux_enabled} = '0;
    end
    // One-cycle write; released lines show inverted junk, never the old value
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'h1;
        @(posedge i_clk);
        o_wr <= 1'h0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    // One-cycle read; the answer stands only in the following cycle
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'h1;
        @(posedge i_clk);
        o_rd <= 1'h0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
    // Software asks for special interrupts port by port
    task automatic request_ports(input logic [7:0] mask);
        write_reg(REG_SPECIAL_REQ, {8'h00, mask});
    endtask
    // Software moves the base only while the multiplexer is off
    task automatic enable_mux(input logic on);
        @(posedge i_clk);
        o_mux_enabled <= on;
    endtask
endmodule

// [testbench/testbench.sv]
module testbench
    import mux_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // One character case: config byte, stimulus, expected result
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] chr;
        logic [2:0] port;
        logic dir;
        logic len8;
        logic [7:0] exp;
        logic spec;
        logic irq;
    } row_type;
    logic i_clk, i_rst, i_wr, i_rd, i_expansion, i_mux_enabled, i_chr_valid, i_cb_req;
    logic i_direction_select_signal, i_port_config_word_len8;
    logic [7:0] i_addr, i_chr;
    logic [15:0] i_wdata, o_rdata, o_cb_addr, rd_data;
    logic [3:0] i_switch;
    logic [2:0] i_chr_port, i_cb_port;
    logic [5:0] i_dev_sel;
    logic o_chr_valid, o_chr_special, o_chr_irq, o_cb_valid, o_sel_mux;
    logic o_sel_console_input_channel, o_sel_console_output_channel;
    logic [7:0] o_chr;
    int fail_count = 0;
    int samples_checked = 0;
    // Port 0 asks for special interrupts, port 1 does not
    row_type rows [16] = '{
        '{8'h00, 8'h1f, 3'h0, 1'h1, 1'h0, 8'h9f, 1'h1, 1'h1},
        '{8'h00, 8'h41, 3'h0, 1'h1, 1'h0, 8'hc1, 1'h0, 1'h0},
        '{8'h00, 8'h20, 3'h1, 1'h1, 1'h0, 8'h20, 1'h0, 1'h0},
        '{8'h00, 8'h7c, 3'h1, 1'h0, 1'h0, 8'h7c, 1'h1, 1'h0},
        '{8'h00, 8'h7b, 3'h0, 1'h0, 1'h0, 8'h7b, 1'h0, 1'h0},
        '{8'h04, 8'h03, 3'h0, 1'h0, 1'h0, 8'h03, 1'h1, 1'h1},
        '{8'h04, 8'h19, 3'h0, 1'h0, 1'h0, 8'h19, 1'h1, 1'h1},
        '{8'h18, 8'h0d, 3'h0, 1'h0, 1'h0, 8'h0d, 1'h1, 1'h1},
        '{8'h18, 8'h5e, 3'h0, 1'h0, 1'h0, 8'h5e, 1'h0, 1'h0},
        '{8'h28, 8'h5e, 3'h0, 1'h0, 1'h0, 8'h5e, 1'h1, 1'h1},
        '{8'h0c, 8'h08, 3'h0, 1'h1, 1'h0, 8'h88, 1'h1, 1'h1},
        '{8'h0c, 8'h08, 3'h0, 1'h0, 1'h0, 8'h08, 1'h0, 1'h0},
        '{8'h0c, 8'h15, 3'h0, 1'h0, 1'h0, 8'h15, 1'h1, 1'h1},
        '{8'h40, 8'h81, 3'h0, 1'h1, 1'h0, 8'h01, 1'h1, 1'h1},
        '{8'h40, 8'h81, 3'h0, 1'h1, 1'h1, 8'h81, 1'h1, 1'h1},
        '{8'h38, 8'hde, 3'h0, 1'h0, 1'h0, 8'hde, 1'h1, 1'h1}};
    // Alternative-code bit, device code, expected {mux, input, output}
    logic [15:0] dev_rows [8] = '{16'h0154, 16'h0082, 16'h0091, 16'h0250,
        16'h1254, 16'h1282, 16'h1291, 16'h1150};
    // Device under test
    mux_cfg_logic dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_expansion, .i_switch, .i_mux_enabled, .i_chr_valid, .i_chr, .i_chr_port,
        .i_direction_select_signal, .i_port_config_word_len8, .o_chr_valid, .o_chr,
        .o_chr_special, .o_chr_irq, .i_cb_req, .i_cb_port, .o_cb_valid, .o_cb_addr,
        .i_dev_sel, .o_sel_mux, .o_sel_console_input_channel, .o_sel_console_output_channel);
    // Processor side of the register port
    host_bus_model host (.i_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd), .o_mux_enabled(i_mux_enabled));
    // Compare a word or character
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Compare a single flag
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask
    // One character slot, checked one cycle later
    task automatic send_chr(input row_type r);
        @(posedge i_clk);
        i_chr_valid <= 1'h1;
        i_chr <= r.chr;
        i_chr_port <= r.port;
        i_direction_select_signal <= r.dir;
        i_port_config_word_len8 <= r.len8;
        @(posedge i_clk);
        i_chr_valid <= 1'h0;
        i_chr <= ~r.chr;
        #1;
    endtask
    // One control block address request
    task automatic cb_check(input logic [2:0] port, input logic [15:0] exp);
        @(posedge i_clk);
        i_cb_req <= 1'h1;
        i_cb_port <= port;
        @(posedge i_clk);
        i_cb_req <= 1'h0;
        #1;
        cmp_flag(o_cb_valid, 1'h1);
        cmp_word(o_cb_addr, exp);
    endtask
    // Verdict and end of run
    task automatic give_verdict;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // 20 MHz clock
    initial begin
        i_clk = 1'h0;
        forever #25 i_clk = ~i_clk;
    end
    // Tests need under 1000 cycles; cut a hang after 20000
    initial begin
        #1000000;
        fail_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        {i_rst, i_expansion, i_chr_valid, i_cb_req} = 4'h8;
        {i_direction_select_signal, i_port_config_word_len8, i_switch} = 6'h00;
        {i_chr, i_chr_port, i_cb_port, i_dev_sel} = 20'h00000;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'h0;
        host.read_reg(REG_CONFIG, rd_data);
        cmp_word(rd_data, 16'h0000);
        host.read_reg(REG_AREA_BASE, rd_data);
        cmp_word(rd_data, 16'h003c);
        host.read_reg(8'h10, rd_data);
        cmp_word(rd_data, 16'h0000);
        host.request_ports(8'h01);
        foreach (rows[i]) begin
            host.write_reg(REG_CONFIG, {8'h00, rows[i].cfg});
            send_chr(rows[i]);
            cmp_flag(o_chr_valid, 1'h1);
            cmp_word({8'h00, o_chr}, {8'h00, rows[i].exp});
            cmp_flag(o_chr_special, rows[i].spec);
            cmp_flag(o_chr_irq, rows[i].irq);
        end
        foreach (dev_rows[i]) begin
            host.write_reg(REG_CONFIG, {8'h00, dev_rows[i][12], 7'h00});
            i_dev_sel <= dev_rows[i][9:4];
            @(posedge i_clk);
            #1;
            cmp_word({13'h0000, o_sel_mux, o_sel_console_input_channel,
                o_sel_console_output_channel}, {13'h0000, dev_rows[i][2:0]});
        end
        host.write_reg(REG_CONFIG, 16'h0600);
        cb_check(3'h3, 16'h3c00 + 16'h0033 * 16'h0020);
        host.write_reg(REG_CONFIG, 16'h0f01);
        cb_check(3'h0, 16'h3c00 + 16'h0078 * 16'h0010);
        @(posedge i_clk);
        i_expansion <= 1'h1;
        i_switch <= 4'h3;
        host.write_reg(REG_CONFIG, 16'h0f02);
        cb_check(3'h7, 16'h3c00 + 16'h001f * 16'h0008);
        host.write_reg(REG_AREA_BASE, 16'h006c);
        cb_check(3'h0, 16'h6c00 + 16'h0018 * 16'h0008);
        host.write_reg(REG_CONFIG, 16'h0003);
        cb_check(3'h1, 16'h6c00 + 16'h0019 * 16'h0020);
        host.enable_mux(1'h1);
        host.write_reg(REG_AREA_BASE, 16'h0010);
        host.read_reg(REG_AREA_BASE, rd_data);
        cmp_word(rd_data, 16'h006c);
        host.enable_mux(1'h0);
        // Second reset in mid-run restores the defaults
        @(posedge i_clk);
        i_rst <= 1'h1;
        @(posedge i_clk);
        i_rst <= 1'h0;
        host.read_reg(REG_AREA_BASE, rd_data);
        cmp_word(rd_data, 16'h003c);
        host.read_reg(REG_SPECIAL_REQ, rd_data);
        cmp_word(rd_data, 16'h0000);
        // Characters on consecutive cycles, each answered in its own slot
        host.request_ports(8'h01);
        @(posedge i_clk);
        i_chr_valid <= 1'h1;
        i_chr <= 8'h1f;
        i_chr_port <= 3'h0;
        i_direction_select_signal <= 1'h1;
        i_port_config_word_len8 <= 1'h0;
        @(posedge i_clk);
        i_chr <= 8'h61;
        #1;
        cmp_word({8'h00, o_chr}, 16'h009f);
        @(posedge i_clk);
        i_chr_valid <= 1'h0;
        #1;
        cmp_word({8'h00, o_chr}, 16'h00e1);
        cmp_flag(o_chr_special, 1'h0);
        // Status shows the switch set and the last adjusted character
        host.read_reg(REG_STATUS, rd_data);
        cmp_word(rd_data, 16'h03e1);
        give_verdict();
    end
endmodule
